// [connector_fixture.sv]
// Fixture on the connector lines, with pull-ups where nobody drives.
`timescale 1ns/100ps
module connector_fixture #(
  parameter W = 8
)(
  input [W-1:0] dev_out,
  input [W-1:0] dev_oe,
  input [W-1:0] ext_val,
  input [W-1:0] ext_en,
  output [W-1:0] wire_lvl
);
  assign wire_lvl = dev_oe & dev_out | ~dev_oe & (ext_en & ext_val | ~ext_en);
endmodule

// [pin_export_checker.sv]
// Concurrent checks on the ports of the timing signal pin export block.
`timescale 1ns/100ps
module pin_export_checker #(
  parameter NPFP = 5
)(
  input clk_sys,
  input nrst,
  input [NPFP-1:0] pfp_drive_en,
  input [NPFP-1:0] programmable_function_pin_oe,
  input [NPFP-1:0] programmable_function_pin_out,
  input acq_begin,
  input pretrig_mode,
  input posttrig_begin,
  input conversion,
  input scan_mode,
  input scan_enable,
  input per_conversion_scan_pulse,
  input strobe_cmd_valid,
  input strobe_cmd_level,
  input soft_strobe_n,
  input counter1_out_int,
  input counter1_output
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire [NPFP-1:0] po = programmable_function_pin_out;
  property p_oe; 1 |=> programmable_function_pin_oe == $past(pfp_drive_en); endproperty
  a_oe: assert property (p_oe) else $error("pin enable late");
  property p_start; acq_begin |-> ##2 po[0] ##1 !po[0]; endproperty
  a_start: assert property (p_start) else $error("start trigger wrong");
  property p_stop; $rose(po[1]) |-> $past(posttrig_begin && pretrig_mode, 2); endproperty
  a_stop: assert property (p_stop) else $error("stop trigger unexpected");
  property p_conv; conversion |-> ##2 !po[2] ##1 po[2]; endproperty
  a_conv: assert property (p_conv) else $error("convert edge wrong");
  property p_scan; per_conversion_scan_pulse == $past(conversion && scan_mode && scan_enable);
  endproperty
  a_scan: assert property (p_scan) else $error("scan pulse wrong");
  property p_stb; strobe_cmd_valid |=> soft_strobe_n == $past(strobe_cmd_level); endproperty
  a_stb: assert property (p_stb) else $error("strobe not set");
  property p_hold; !strobe_cmd_valid |=> $stable(soft_strobe_n); endproperty
  a_hold: assert property (p_hold) else $error("strobe moved");
  property p_c1; 1 |=> counter1_output == $past(counter1_out_int); endproperty
  a_c1: assert property (p_c1) else $error("counter output wrong");
  c_pre: cover property (pretrig_mode && posttrig_begin);
  c_scan: cover property (per_conversion_scan_pulse);
  c_stb: cover property ($fell(soft_strobe_n));
endmodule
bind timing_signal_pin_export pin_export_checker #(.NPFP(NPFP)) u_chk (.*);

// [pin_input_sync.v]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
module pin_input_sync #(
  parameter WIDTH = 1
)(
  input wire clk_sys,
  input wire nrst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  genvar i;
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= {WIDTH{1'b0}};
      s2_ff <= {WIDTH{1'b0}};
      s3_ff <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_ff <= async_in;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end
  // A change is taken only once stages two and three agree.
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
          sync_out[i] <= 1'b0;
        else if (s2_ff[i] == s3_ff[i])
          sync_out[i] <= s3_ff[i];
      end
    end
  endgenerate
endmodule

// [timing_pin_export_regs.vh]
// Constants for the timing signal pin export block.
`ifndef TIMING_PIN_EXPORT_REGS_VH
`define TIMING_PIN_EXPORT_REGS_VH
`define PFP_COUNT 5
`define PFP_START 0
`define PFP_STOP 1
`define PFP_CONV 2
`define PFP_SRC 3
`define PFP_GATE 4
`define PFP_OE_RST 5'h00
`define STROBE_RST 1'b1
`define CONV_N_RST 1'b1
`define PPI_WIDTH 8
`define DIO_WIDTH 8
`define DIO_DIR0 6
`define DIO_DIR1 7
`define SCAN_PULSE_CYC 1
`endif

// [timing_signal_pin_export.v]
// Connector-side routing of acquisition timing signals and digital lines.
//
// Summary of operation
// [R1] Each function pin is a trigger input while its driver is off and drives its own timing signal when on.
// [R2] Without pretrigger, the exported start trigger rises when the acquisition sequence begins.
// [R3] With pretrigger, the exported start trigger rises when the pretrigger conversions begin.
// [R4] With pretrigger, the exported stop trigger rises when the posttrigger conversions begin.
// [R5] Without pretrigger, the stop trigger takes no part and the sequence completes without it.
// [R6] The active-low conversion output falls once for each conversion.
// [R7] The scan pulse output pulses once per conversion in scanning mode when enabled, else stays idle.
// [R8] The scan pulse rising edge marks when the outside may remove or switch the input.
// [R9] The active-low strobe output changes level only on software command.
// [R10] The exported counter 1 source pin reproduces the selected counter 1 count source.
// [R11] The exported counter 1 gate pin reproduces the selected counter 1 gate.
// [R12] The counter 1 output pin always carries counter 1's output.
// [R13] Digital lines 6 and 7 can act as up/down controls of counters 0 and 1 besides plain I/O.
// [R14] Each peripheral port is eight two-way lines with line 7 the MSB and line 0 the LSB.
// [R15] Each function pin driver is enabled by its own control bit and is off after reset.
`timescale 1ns/100ps
`include "timing_pin_export_regs.vh"
module timing_signal_pin_export #(
  parameter NPFP = `PFP_COUNT,
  parameter PPIW = `PPI_WIDTH,
  parameter DIOW = `DIO_WIDTH
)(
  input wire clk_sys,
  input wire nrst,
  input wire [NPFP-1:0] pfp_drive_en,
  input wire acq_begin,
  input wire pretrig_mode,
  input wire posttrig_begin,
  input wire conversion,
  input wire scan_mode,
  input wire scan_enable,
  input wire strobe_cmd_valid,
  input wire strobe_cmd_level,
  input wire counter1_source_sel,
  input wire counter1_gate_sel,
  input wire counter1_out_int,
  input wire [NPFP-1:0] programmable_function_pin_in,
  output reg [NPFP-1:0] programmable_function_pin_out,
  output reg [NPFP-1:0] programmable_function_pin_oe,
  output reg [NPFP-1:0] pfp_trigger_in,
  output reg per_conversion_scan_pulse,
  output reg soft_strobe_n,
  output reg counter1_output,
  input wire [DIOW-1:0] general_digital_lines_in,
  input wire [DIOW-1:0] dio_out_val,
  input wire [DIOW-1:0] dio_dir,
  output reg [DIOW-1:0] general_digital_lines_out,
  output reg [DIOW-1:0] general_digital_lines_oe,
  output reg [DIOW-1:0] dio_read,
  output reg counter0_up_down,
  output reg counter1_up_down,
  input wire [PPIW-1:0] ppi_port_a_lines_in,
  input wire [PPIW-1:0] ppi_port_b_lines_in,
  input wire [PPIW-1:0] ppi_port_c_lines_in,
  input wire [3*PPIW-1:0] ppi_out_val,
  input wire [2:0] ppi_port_dir,
  output reg [PPIW-1:0] ppi_port_a_lines_out,
  output reg [PPIW-1:0] ppi_port_b_lines_out,
  output reg [PPIW-1:0] ppi_port_c_lines_out,
  output reg [2:0] ppi_port_oe,
  output reg [3*PPIW-1:0] ppi_read
);
  reg ai_start_trigger_ff;
  reg ai_stop_trigger_ff;
  reg conv_n_ff;
  reg acq_run_ff;
  reg [NPFP-1:0] nxt_pfp_out;
  wire [NPFP-1:0] pfp_sync;
  wire [DIOW-1:0] dio_sync;
  wire [3*PPIW-1:0] ppi_sync;

  pin_input_sync #(.WIDTH(NPFP)) u_pfp_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(programmable_function_pin_in),
    .sync_out(pfp_sync)
  );

  pin_input_sync #(.WIDTH(DIOW)) u_dio_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in(general_digital_lines_in),
    .sync_out(dio_sync)
  );

  pin_input_sync #(.WIDTH(3*PPIW)) u_ppi_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in({ppi_port_c_lines_in, ppi_port_b_lines_in, ppi_port_a_lines_in}),
    .sync_out(ppi_sync)
  );

  // Acquisition trigger levels; the start trigger returns low the next cycle, the stop trigger when the sequence is idle again.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      acq_run_ff <= 1'b0;
      ai_start_trigger_ff <= 1'b0;
      ai_stop_trigger_ff <= 1'b0;
    end
    else if (acq_begin)
    begin
      acq_run_ff <= 1'b1;
      ai_start_trigger_ff <= 1'b1; // [R2] [R3]
      ai_stop_trigger_ff <= 1'b0;
    end
    else if (acq_run_ff && posttrig_begin && pretrig_mode)
    begin
      ai_start_trigger_ff <= 1'b0;
      ai_stop_trigger_ff <= 1'b1; // [R4]
    end
    else
    begin
      // The start trigger is a one-cycle rising pulse; without pretrigger the stop stays low.
      ai_start_trigger_ff <= 1'b0;
      if (!pretrig_mode)
      begin
        ai_stop_trigger_ff <= 1'b0; // [R5]
        acq_run_ff <= 1'b0; // [R5]
      end
      else if (ai_stop_trigger_ff)
      begin
        ai_stop_trigger_ff <= 1'b0;
        acq_run_ff <= 1'b0;
      end
    end
  end

  // Conversion output is low for the cycle after each conversion.
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      conv_n_ff <= `CONV_N_RST;
    else
      conv_n_ff <= ~conversion; // [R6]
  end

  always @*
  begin
    nxt_pfp_out = {NPFP{1'b0}};
    nxt_pfp_out[`PFP_START] = ai_start_trigger_ff;
    nxt_pfp_out[`PFP_STOP] = ai_stop_trigger_ff;
    nxt_pfp_out[`PFP_CONV] = conv_n_ff;
    nxt_pfp_out[`PFP_SRC] = counter1_source_sel; // [R10]
    nxt_pfp_out[`PFP_GATE] = counter1_gate_sel; // [R11]
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      programmable_function_pin_out <= {NPFP{1'b0}};
      programmable_function_pin_oe <= `PFP_OE_RST; // [R15]
      pfp_trigger_in <= {NPFP{1'b0}};
      per_conversion_scan_pulse <= 1'b0;
      soft_strobe_n <= `STROBE_RST;
      counter1_output <= 1'b0;
    end
    else
    begin
      programmable_function_pin_out <= nxt_pfp_out; // [R1]
      programmable_function_pin_oe <= pfp_drive_en; // [R15]
      pfp_trigger_in <= pfp_sync & ~pfp_drive_en; // [R1]
      // Rising edge one cycle after the conversion lets the outside switch inputs.
      per_conversion_scan_pulse <= conversion & scan_mode & scan_enable; // [R7] [R8]
      if (strobe_cmd_valid)
        soft_strobe_n <= strobe_cmd_level; // [R9]
      counter1_output <= counter1_out_int; // [R12]
    end
  end

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      general_digital_lines_out <= {DIOW{1'b0}};
      general_digital_lines_oe <= {DIOW{1'b0}};
      dio_read <= {DIOW{1'b0}};
      counter0_up_down <= 1'b0;
      counter1_up_down <= 1'b0;
      ppi_port_a_lines_out <= {PPIW{1'b0}};
      ppi_port_b_lines_out <= {PPIW{1'b0}};
      ppi_port_c_lines_out <= {PPIW{1'b0}};
      ppi_port_oe <= 3'h0;
      ppi_read <= {3*PPIW{1'b0}};
    end
    else
    begin
      general_digital_lines_out <= dio_out_val;
      general_digital_lines_oe <= dio_dir;
      dio_read <= dio_sync;
      // Up/down follows the line level, whether driven here or from outside.
      counter0_up_down <= dio_dir[`DIO_DIR0] ? dio_out_val[`DIO_DIR0] : dio_sync[`DIO_DIR0]; // [R13]
      counter1_up_down <= dio_dir[`DIO_DIR1] ? dio_out_val[`DIO_DIR1] : dio_sync[`DIO_DIR1]; // [R13]
      // Bit index equals line number, so line 7 is the MSB.
      ppi_port_a_lines_out <= ppi_out_val[PPIW-1:0]; // [R14]
      ppi_port_b_lines_out <= ppi_out_val[2*PPIW-1:PPIW]; // [R14]
      ppi_port_c_lines_out <= ppi_out_val[3*PPIW-1:2*PPIW]; // [R14]
      ppi_port_oe <= ppi_port_dir; // [R14]
      ppi_read <= ppi_sync; // [R14]
    end
  end
endmodule

// [timing_signal_pin_export_tb.sv]
// Self-checking testbench for the timing signal pin export block.
`timescale 1ns/100ps
module timing_signal_pin_export_tb;
  logic clk_sys = 0, nrst = 0, acq_begin = 0, pretrig_mode = 0, posttrig_begin = 0;
  logic conversion = 0, scan_mode = 0, scan_enable = 0, strobe_cmd_valid = 0;
  logic strobe_cmd_level = 0, counter1_source_sel = 0, counter1_gate_sel = 0;
  logic counter1_out_int = 0;
  logic [4:0] pfp_drive_en = 0, pfp_ext = 0;
  logic [7:0] dio_out_val = 8'h80, dio_dir = 0, dio_en = 0;
  logic [23:0] ppi_out_val = 0, ppi_en = 0;
  logic [2:0] ppi_port_dir = 0;
  wire [4:0] programmable_function_pin_out, programmable_function_pin_oe;
  wire [4:0] pfp_trigger_in, programmable_function_pin_in;
  wire per_conversion_scan_pulse, soft_strobe_n, counter1_output;
  wire counter0_up_down, counter1_up_down;
  wire [7:0] general_digital_lines_out, general_digital_lines_oe, dio_read;
  wire [7:0] general_digital_lines_in, ppi_port_a_lines_out;
  wire [7:0] ppi_port_b_lines_out, ppi_port_c_lines_out;
  wire [2:0] ppi_port_oe;
  wire [23:0] ppi_read, ppi_wire;
  wire [7:0] ppi_port_a_lines_in = ppi_wire[7:0];
  wire [7:0] ppi_port_b_lines_in = ppi_wire[15:8];
  wire [7:0] ppi_port_c_lines_in = ppi_wire[23:16];
  integer mismatches = 0, checks_done = 0, cycles = 0;
  timing_signal_pin_export DUT (.*);
  connector_fixture #(.W(5)) u_pfp (.dev_out(programmable_function_pin_out),
    .dev_oe(programmable_function_pin_oe), .ext_val(pfp_ext), .ext_en(5'h1f),
    .wire_lvl(programmable_function_pin_in));
  connector_fixture u_dio (.dev_out(general_digital_lines_out), .dev_oe(general_digital_lines_oe),
    .ext_val(8'h3f), .ext_en(dio_en), .wire_lvl(general_digital_lines_in));
  connector_fixture #(.W(24)) u_ppi (.dev_out({ppi_port_c_lines_out, ppi_port_b_lines_out,
    ppi_port_a_lines_out}), .dev_oe({{8{ppi_port_oe[2]}}, {8{ppi_port_oe[1]}},
    {8{ppi_port_oe[0]}}}), .ext_val(24'h002d00), .ext_en(ppi_en), .wire_lvl(ppi_wire));
  always #5 clk_sys = ~clk_sys;
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  task t_seq(input logic pre);
    pretrig_mode = pre;
    acq_begin = 1;
    cyc(1);
    acq_begin = 0;
    posttrig_begin = 1;
    cyc(1);
    posttrig_begin = 0;
    chk("start", 1, programmable_function_pin_out[0]);
    cyc(1);
    chk("start", 0, programmable_function_pin_out[0]);
    chk("stop", pre, programmable_function_pin_out[1]);
    cyc(1);
    chk("stop", 0, programmable_function_pin_out[1]);
  endtask
  task t_conv(input logic en);
    scan_mode = 1;
    scan_enable = en;
    conversion = 1;
    cyc(1);
    conversion = 0;
    chk("scan", en, per_conversion_scan_pulse);
    if (per_conversion_scan_pulse) pfp_ext = ~pfp_ext;
    cyc(1);
    chk("scan", 0, per_conversion_scan_pulse);
    chk("convert", 0, programmable_function_pin_out[2]);
    cyc(1);
    chk("convert", 1, programmable_function_pin_out[2]);
  endtask
  task t_strobe(input logic lv);
    strobe_cmd_valid = 1;
    strobe_cmd_level = lv;
    cyc(1);
    strobe_cmd_valid = 0;
    strobe_cmd_level = !lv;
    chk("strobe", lv, soft_strobe_n);
    cyc(3);
    chk("strobe", lv, soft_strobe_n);
  endtask
  task t_pins(input logic [4:0] en, input logic [4:0] ext, input logic [2:0] c1);
    pfp_drive_en = en;
    pfp_ext = ext;
    {counter1_gate_sel, counter1_source_sel, counter1_out_int} = c1;
    cyc(8);
    chk("oe", en, programmable_function_pin_oe);
    chk("trig", ext & ~en, pfp_trigger_in);
    chk("ctr1", c1, {programmable_function_pin_out[4:3], counter1_output});
  endtask
  task t_dio(input logic [7:0] dir, input logic [7:0] en, input logic [1:0] up, input logic [7:0] rd);
    dio_dir = dir;
    dio_en = en;
    cyc(8);
    chk("updown", up, {counter1_up_down, counter0_up_down});
    chk("dio", rd, dio_read);
  endtask
  task t_ppi;
    ppi_port_dir = 3'b001;
    ppi_out_val = 24'h00001e;
    ppi_en = 24'h00ff00;
    cyc(8);
    chk("ppi", 24'hff2d1e, ppi_read);
  endtask
  task conclude;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      conclude;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    cyc(1);
    nrst = 1;
    chk("oe", 0, programmable_function_pin_oe);
    t_seq(0);
    t_seq(1);
    t_conv(1);
    t_conv(0);
    t_strobe(0);
    t_strobe(1);
    t_pins(5'h18, 5'h15, 3'b011);
    t_pins(5'h00, 5'h0a, 3'b100);
    t_dio(8'h80, 8'h7f, 2'b10, 8'hbf);
    t_dio(8'h00, 8'h3f, 2'b11, 8'hff);
    t_ppi;
    conclude;
  end
endmodule
